// File: dv/asp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module asp_host_model (
    // clock and mode
    input wire logic sys_clk,
    input wire logic mode,
    // device side
    input wire logic sclk_o,
    input wire logic sclk_oe,
    input wire logic sd_o,
    input wire logic sd_oe,
    // resolved pins
    output logic     sclk_w,
    output logic     sd_w,
    output logic     rd_sync_n = 1'b1,
    output logic     wr_sync_n = 1'b1,
    output logic     sel = 1'b0
);
    logic hs  = 1'b0;
    logic hd  = 1'b0;
    logic hoe = 1'b0;
    logic flt = 1'b0;
    // no pull on data: a free line must not look like old data
    always_ff @(posedge sys_clk) flt <= ~flt;
    assign sclk_w = sclk_oe ? sclk_o : (mode ? 1'b1 : hs);
    assign sd_w   = sd_oe ? sd_o : (hoe ? hd : flt);
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wt
    // 6+7 cycle phases give the 130 ns link period
    task automatic xfer(input logic rd, input logic s, input int n,
                        input logic [23:0] w, input int pause,
                        output logic [23:0] r);
        r = 24'h000000;
        sel <= s;
        hoe <= !rd;
        rd_sync_n <= !rd;
        wr_sync_n <= rd;
        wt(8);
        for (int i = 0; i < n; i++) begin
            hd <= w[23-i];
            if (mode) begin
                // own clock: sample on the rise, next bit after the fall
                @(posedge sclk_w);
                r = {r[22:0], sd_w};
                @(negedge sclk_w);
            end else begin
                wt(7);
                r = {r[22:0], sd_w};
                hs <= 1'b1;
                wt(6);
                hs <= 1'b0;
                if (i + 1 == pause) begin
                    wt(3);
                    rd_sync_n <= 1'b1;
                    wr_sync_n <= 1'b1;
                    wt(12);
                    rd_sync_n <= !rd;
                    wr_sync_n <= rd;
                    wt(8);
                end
            end
        end
        wt(8);
        rd_sync_n <= 1'b1;
        wr_sync_n <= 1'b1;
        hoe <= 1'b0;
        wt(10);
    endtask : xfer
endmodule : asp_host_model
`default_nettype wire

// File: dv/asp_sp_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "asp_defines.svh"
module asp_sp_asserts (
    // clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rst,
    // watched ports
    input wire logic                  mode,
    input wire logic                  read_frame_sync_n,
    input wire logic                  register_select,
    input wire logic                  sclk_o,
    input wire logic                  sclk_oe,
    input wire logic                  serial_data_oe,
    input wire logic                  data_ready_n,
    input wire logic                  conv_valid,
    input wire logic                  cal_wr_stb,
    input wire logic [`ASP_REG_W-1:0] ctrl_word
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    //--------------------------------------------------------
    // pin behaviour
    //--------------------------------------------------------
    a_rdy_set_cause: assert property (
        $fell(data_ready_n) |-> $past(conv_valid) || $past(conv_valid, 2))
        else $error("data ready fell without a new word");
    a_rdy_end_release: assert property (
        $rose(data_ready_n) |-> $fell(serial_data_oe))
        else $error("data line kept after data ready rose");
    a_drive_needs_sync: assert property (
        $rose(serial_data_oe) |-> !$past(read_frame_sync_n, 3))
        else $error("data line driven without read sync");
    a_pause_release: assert property (
        $rose(read_frame_sync_n) |-> ##[1:8] !serial_data_oe)
        else $error("data line not released on read sync rise");
    a_out_read_gate: assert property (
        $rose(serial_data_oe) && $past(register_select, 3)
        && !ctrl_word[`ASP_CTRL_CALRD_BIT] |-> !data_ready_n)
        else $error("output read served with no word ready");
    a_ext_no_clock: assert property (
        sclk_oe |-> mode)
        else $error("clock driven in external mode");
    a_cal_wr_alone: assert property (
        cal_wr_stb |-> $stable(ctrl_word) ##1 !cal_wr_stb)
        else $error("calibration write disturbed control word");
    a_wr_keeps_rdy: assert property (
        $changed(ctrl_word) |-> $stable(data_ready_n))
        else $error("write changed data ready");
    a_self_half: assert property (
        $rose(sclk_o) && sclk_oe |-> ##[18:22] $fell(sclk_o))
        else $error("own clock high phase wrong");
endmodule : asp_sp_asserts
bind asp_serial_port asp_sp_asserts chk_u (.*);
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        mode = 1'b0;
    logic        conv_valid = 1'b0;
    logic [23:0] conv_word = 24'h000000;
    logic [23:0] cal_rd_data = 24'hC3A5F0;
    logic        sclk_w, sd_w, rd_sync_n, wr_sync_n, sel, stb;
    logic        sclk_o, sclk_oe, sd_o, sd_oe, rdy_n;
    logic        oe_seen = 1'b0;
    logic [23:0] ctrl, cal_d, r;
    int          err_total = 0;
    int          checked = 0;
    int          cyc = 0;
    int          stb_n = 0;
    asp_serial_port dut_u (.sys_clk(sys_clk), .rst(rst), .mode(mode),
        .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
        .read_frame_sync_n(rd_sync_n), .write_frame_sync_n(wr_sync_n),
        .register_select(sel), .serial_data_i(sd_w),
        .serial_data_o(sd_o), .serial_data_oe(sd_oe),
        .data_ready_n(rdy_n), .conv_word(conv_word),
        .conv_valid(conv_valid), .cal_rd_data(cal_rd_data),
        .ctrl_word(ctrl), .cal_wr_stb(stb), .cal_wr_data(cal_d));
    asp_host_model host_u (.sys_clk(sys_clk), .mode(mode),
        .sclk_o(sclk_o), .sclk_oe(sclk_oe), .sd_o(sd_o), .sd_oe(sd_oe),
        .sclk_w(sclk_w), .sd_w(sd_w), .rd_sync_n(rd_sync_n),
        .wr_sync_n(wr_sync_n), .sel(sel));
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (stb === 1'b1) stb_n <= stb_n + 1;
        if (sd_oe === 1'b1) oe_seen <= 1'b1;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        if (err_total == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic do_reset(input logic m);
        rst <= 1'b1;
        mode <= m;
        host_u.wt(5);
        rst <= 1'b0;
        host_u.wt(8);
    endtask : do_reset
    task automatic conv(input logic [23:0] w);
        conv_word <= w;
        conv_valid <= 1'b1;
        host_u.wt(1);
        conv_valid <= 1'b0;
        host_u.wt(5);
    endtask : conv
    //------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------
    task automatic s_write;
        host_u.xfer(0, 0, 24, 24'h0002A5, 11, r);
        chk(ctrl, 24'h0002A5);
        chk(rdy_n, 1'b1);
        stb_n = 0;
        host_u.xfer(0, 1, 24, 24'h5A3C96, 0, r);
        chk(cal_d, 24'h5A3C96);
        chk(24'(stb_n), 24'h000001);
        chk(ctrl, 24'h0002A5);
    endtask : s_write
    task automatic s_refused;
        oe_seen = 1'b0;
        host_u.xfer(1, 1, 24, 24'h000000, 0, r);
        chk(oe_seen, 1'b0);
        chk(rdy_n, 1'b1);
    endtask : s_refused
    task automatic s_out;
        conv(24'h13579B);
        conv(24'hECA864);
        chk(rdy_n, 1'b0);
        fork
            host_u.xfer(1, 1, 24, 24'h000000, 9, r);
            begin
                host_u.wt(120);
                conv(24'h777777);
            end
        join
        chk(r, 24'hECA864);
        chk(rdy_n, 1'b1);
    endtask : s_out
    task automatic s_reg_rd;
        conv(24'h2468AC);
        host_u.xfer(1, 0, 24, 24'h000000, 0, r);
        chk(r, 24'h0002A5);
        chk(rdy_n, 1'b0);
        host_u.xfer(0, 0, 24, 24'h000000, 0, r);
        chk(rdy_n, 1'b0);
        host_u.xfer(1, 1, 16, 24'h000000, 0, r);
        chk(r, 24'h002468);
        chk(rdy_n, 1'b1);
    endtask : s_reg_rd
    // self clocking starts from a reset, though mode is resynchronised every cycle
    task automatic s_self;
        do_reset(1'b1);
        host_u.xfer(0, 0, 24, 24'h00035A, 0, r);
        host_u.wt(4);
        chk(ctrl, 24'h00035A);
        chk(sclk_oe, 1'b0);
        host_u.xfer(1, 0, 24, 24'h000000, 0, r);
        host_u.wt(4);
        chk(r, 24'h00035A);
        chk(sclk_oe, 1'b0);
        host_u.xfer(1, 1, 24, 24'h000000, 0, r);
        chk(r, 24'hC3A5F0);
        chk(rdy_n, 1'b1);
    endtask : s_self
    initial begin
        do_reset(1'b0);
        s_write();
        s_refused();
        s_out();
        s_reg_rd();
        s_self();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire

// File: src/asp_defines.svh
//------------------------------------------------------------------------
// Summary of operation
// - writes ignore and never change data-ready
// - select picks write target, held stable
// - self mode: write sync fall starts clock
// - self mode: write bits sampled on rises
// - self mode: clock stops after final fall
// - mode low selects external clocking
// - select picks read source, held stable
// - new conversion drives data-ready low
// - last word bit read raises data-ready
// - unread word keeps updating, newest returned
// - result during output read is dropped
// - register reads leave data-ready alone
// - output read refused while data-ready high
// - external read: MSB on sync, shift falls
// - final fall raises data-ready, releases line
// - read pause releases line, resumes next bit
// - external write: capture on clock rise
// - write pause resumes with next bit
// - mode high selects self clocking
// - self mode: read sync starts clock
//------------------------------------------------------------------------
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

`define ASP_CLK_MHZ         100
`define ASP_SCLK_HALF_NS    200
`define ASP_SCLK_HALF_CYC   ((`ASP_SCLK_HALF_NS * `ASP_CLK_MHZ) / 1000)
`define ASP_TMR_W           8

`define ASP_REG_W           24
`define ASP_LEN_LONG        5'h18
`define ASP_LEN_SHORT       5'h10
`define ASP_CNT_W           5

`define ASP_CTRL_RST        24'h000000
`define ASP_CTRL_WL_BIT     9
`define ASP_CTRL_CALRD_BIT  8

`define ASP_IN_N            6
`define ASP_IN_SCLK         0
`define ASP_IN_RFS          1
`define ASP_IN_TFS          2
`define ASP_IN_SDI          3
`define ASP_IN_SEL          4
`define ASP_IN_MODE         5
`define ASP_IN_IDLE         6'h06

`endif

// File: src/asp_pkg.sv
`default_nettype none
`include "asp_defines.svh"

package asp_pkg;

    typedef enum logic [2:0] {
        ASP_IDLE,
        ASP_READ,
        ASP_WRITE,
        ASP_WEND,
        ASP_HOLD
    } asp_state_t;

    typedef struct packed {
        logic [`ASP_IN_N-1:0]  s1;
        logic [`ASP_IN_N-1:0]  s2;
        logic [`ASP_IN_N-1:0]  s3;
        logic [`ASP_IN_N-1:0]  filt;
        asp_state_t            st;
        logic                  is_out;
        logic                  sel_wr;
        logic [`ASP_CNT_W-1:0] cnt;
        logic [`ASP_CNT_W-1:0] len;
        logic [`ASP_REG_W-1:0] sh;
        logic [`ASP_REG_W-1:0] out_word;
        logic [`ASP_REG_W-1:0] ctrl;
        logic                  data_ready_n_n;
        logic                  sd_o;
        logic                  sd_oe;
        logic                  sck;
        logic                  sck_oe;
        logic [`ASP_TMR_W-1:0] tmr;
        logic                  cal_stb;
        logic [`ASP_REG_W-1:0] cal_data;
    } asp_regs_t;

endpackage : asp_pkg

`default_nettype wire

// File: src/asp_serial_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "asp_defines.svh"

module asp_serial_port (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // serial pins
    input  wire logic                  mode,
    input  wire logic                  sclk_i,
    output logic                       sclk_o,
    output logic                       sclk_oe,
    input  wire logic                  read_frame_sync_n,
    input  wire logic                  write_frame_sync_n,
    input  wire logic                  register_select,
    input  wire logic                  serial_data_i,
    output logic                       serial_data_o,
    output logic                       serial_data_oe,
    output logic                       data_ready_n,
    // conversion side
    input  wire logic [`ASP_REG_W-1:0] conv_word,
    input  wire logic                  conv_valid,
    input  wire logic [`ASP_REG_W-1:0] cal_rd_data,
    output logic [`ASP_REG_W-1:0]      ctrl_word,
    output logic                       cal_wr_stb,
    output logic [`ASP_REG_W-1:0]      cal_wr_data
);

    //--------------------------------------------------------------------
    // state
    //--------------------------------------------------------------------
    asp_pkg::asp_regs_t r;
    asp_pkg::asp_regs_t next_r;

    logic [`ASP_IN_N-1:0] pins;
    logic                 self_clk;
    logic                 x_rise;
    logic                 x_fall;
    logic                 i_rise;
    logic                 i_fall;
    logic                 rise;
    logic                 fall;
    logic                 rfs_fall;
    logic                 rfs_rise;
    logic                 tfs_fall;
    logic                 frame_lo;
    logic                 sel;
    logic                 cal_rd;

    assign pins = {mode, register_select, serial_data_i,
                   write_frame_sync_n, read_frame_sync_n, sclk_i};

    //--------------------------------------------------------------------
    // next state
    //--------------------------------------------------------------------
    always_comb begin
        next_r         = r;
        next_r.cal_stb = 1'b0;

        // three-stage synchroniser; a level counts once stages 2, 3 agree
        next_r.s1 = pins;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        for (int i = 0; i < `ASP_IN_N; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                next_r.filt[i] = r.s3[i];
            end
        end

        self_clk = r.filt[`ASP_IN_MODE];
        // select is taken with the frame sync edge, same pipeline depth
        sel      = next_r.filt[`ASP_IN_SEL];
        cal_rd   = r.ctrl[`ASP_CTRL_CALRD_BIT];
        x_rise   = next_r.filt[`ASP_IN_SCLK] & ~r.filt[`ASP_IN_SCLK];
        x_fall   = ~next_r.filt[`ASP_IN_SCLK] & r.filt[`ASP_IN_SCLK];
        rfs_fall = ~next_r.filt[`ASP_IN_RFS] & r.filt[`ASP_IN_RFS];
        rfs_rise = next_r.filt[`ASP_IN_RFS] & ~r.filt[`ASP_IN_RFS];
        tfs_fall = ~next_r.filt[`ASP_IN_TFS] & r.filt[`ASP_IN_TFS];

        // own clock advances while the active frame sync is low, and always in ASP_WEND
        if (r.st == asp_pkg::ASP_READ) begin
            frame_lo = ~r.filt[`ASP_IN_RFS];
        end else if (r.st == asp_pkg::ASP_WRITE) begin
            frame_lo = ~r.filt[`ASP_IN_TFS];
        end else begin
            frame_lo = 1'b1;
        end

        //----------------------------------------------------------------
        // self-clock generator, idles high like a pulled-up line
        //----------------------------------------------------------------
        i_rise = 1'b0;
        i_fall = 1'b0;
        if (r.sck_oe && frame_lo) begin
            if (r.tmr == `ASP_TMR_W'(`ASP_SCLK_HALF_CYC - 1)) begin
                next_r.tmr = '0;
                next_r.sck = ~r.sck;
                i_rise     = ~r.sck;
                i_fall     = r.sck;
            end else begin
                next_r.tmr = r.tmr + `ASP_TMR_W'(1);
            end
        end
        rise = self_clk ? i_rise : x_rise;
        fall = self_clk ? i_fall : x_fall;

        //----------------------------------------------------------------
        // conversion results; dropped while the output word is in flight
        //----------------------------------------------------------------
        if (conv_valid && !(r.st == asp_pkg::ASP_READ && r.is_out)) begin
            next_r.out_word = conv_word;
            next_r.data_ready_n_n   = 1'b0;
        end

        //----------------------------------------------------------------
        // transfer sequencing
        //----------------------------------------------------------------
        case (r.st)
            asp_pkg::ASP_IDLE: begin
                if (rfs_fall) begin
                    next_r.cnt    = '0;
                    next_r.is_out = 1'b0;
                    next_r.len    = `ASP_LEN_LONG;
                    if (sel && !cal_rd) begin
                        next_r.is_out = 1'b1;
                        next_r.sh     = r.out_word;
                        if (!r.ctrl[`ASP_CTRL_WL_BIT]) begin
                            next_r.len = `ASP_LEN_SHORT;
                        end
                    end else if (sel) begin
                        next_r.sh = cal_rd_data;
                    end else begin
                        next_r.sh = r.ctrl;
                    end
                    if (sel && !cal_rd && r.data_ready_n_n) begin
                        // refused: nothing moves until the frame ends
                        next_r.st = asp_pkg::ASP_HOLD;
                    end else begin
                        next_r.st    = asp_pkg::ASP_READ;
                        next_r.sd_oe = 1'b1;
                        if (sel && !cal_rd) begin
                            next_r.sd_o = r.out_word[`ASP_REG_W-1];
                        end else if (sel) begin
                            next_r.sd_o = cal_rd_data[`ASP_REG_W-1];
                        end else begin
                            next_r.sd_o = r.ctrl[`ASP_REG_W-1];
                        end
                        if (self_clk) begin
                            next_r.sck_oe = 1'b1;
                            next_r.sck    = 1'b1;
                            next_r.tmr    = '0;
                            // first own fall is a lead-in: one more to count
                            next_r.len    = next_r.len + `ASP_CNT_W'(1);
                        end
                    end
                end else if (tfs_fall) begin
                    next_r.st     = asp_pkg::ASP_WRITE;
                    next_r.cnt    = '0;
                    next_r.sel_wr = sel;
                    if (self_clk) begin
                        next_r.sck_oe = 1'b1;
                        next_r.sck    = 1'b1;
                        next_r.tmr    = '0;
                    end
                end
            end

            asp_pkg::ASP_READ: begin
                if (rfs_rise) begin
                    next_r.sd_oe = 1'b0;
                end else if (rfs_fall) begin
                    next_r.sd_oe = 1'b1;
                end
                if (fall && frame_lo) begin
                    next_r.cnt = r.cnt + `ASP_CNT_W'(1);
                    if (r.cnt + `ASP_CNT_W'(1) == r.len) begin
                        // final fall: word complete, line released
                        if (r.is_out) begin
                            next_r.data_ready_n_n = 1'b1;
                        end
                        next_r.sd_oe  = 1'b0;
                        // own clock shows this fall, then lets go
                        next_r.st     = self_clk ? asp_pkg::ASP_WEND
                                                 : asp_pkg::ASP_HOLD;
                    end else if (!(self_clk && r.cnt == '0)) begin
                        next_r.sh   = {r.sh[`ASP_REG_W-2:0], 1'b0};
                        next_r.sd_o = r.sh[`ASP_REG_W-2];
                    end
                end
            end

            asp_pkg::ASP_WRITE: begin
                // rises outside a low frame sync are a pause, not a bit
                if (rise && frame_lo) begin
                    next_r.sh  = {r.sh[`ASP_REG_W-2:0],
                                  r.filt[`ASP_IN_SDI]};
                    next_r.cnt = r.cnt + `ASP_CNT_W'(1);
                    if (r.cnt + `ASP_CNT_W'(1) == `ASP_LEN_LONG) begin
                        if (r.sel_wr) begin
                            next_r.cal_stb  = 1'b1;
                            next_r.cal_data = {r.sh[`ASP_REG_W-2:0],
                                               r.filt[`ASP_IN_SDI]};
                        end else begin
                            next_r.ctrl = {r.sh[`ASP_REG_W-2:0],
                                           r.filt[`ASP_IN_SDI]};
                        end
                        next_r.st = self_clk ? asp_pkg::ASP_WEND
                                             : asp_pkg::ASP_HOLD;
                    end
                end
            end

            asp_pkg::ASP_WEND: begin
                // the closing fall stays driven for one half period,
                // otherwise the pull-up would hide it from the host
                if (i_rise) begin
                    next_r.sck_oe = 1'b0;
                    next_r.sck    = 1'b1;
                    next_r.st     = asp_pkg::ASP_HOLD;
                end
            end

            asp_pkg::ASP_HOLD: begin
                if (r.filt[`ASP_IN_RFS] && r.filt[`ASP_IN_TFS]) begin
                    next_r.st = asp_pkg::ASP_IDLE;
                end
            end

            default: begin
                next_r.st     = asp_pkg::ASP_IDLE;
                next_r.sd_oe  = 1'b0;
                next_r.sck_oe = 1'b0;
            end
        endcase
    end

    //--------------------------------------------------------------------
    // registers
    //--------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r        <= '0;
            r.s1     <= `ASP_IN_IDLE;
            r.s2     <= `ASP_IN_IDLE;
            r.s3     <= `ASP_IN_IDLE;
            r.filt   <= `ASP_IN_IDLE;
            r.data_ready_n_n <= 1'b1;
            r.sck    <= 1'b1;
            r.ctrl   <= `ASP_CTRL_RST;
        end else begin
            r <= next_r;
        end
    end

    //--------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------
    assign sclk_o         = r.sck;
    assign sclk_oe        = r.sck_oe;
    assign serial_data_o  = r.sd_o;
    assign serial_data_oe = r.sd_oe;
    assign data_ready_n   = r.data_ready_n_n;
    assign ctrl_word      = r.ctrl;
    assign cal_wr_stb     = r.cal_stb;
    assign cal_wr_data    = r.cal_data;

endmodule : asp_serial_port

`default_nettype wire
